/* rtl/pwem_device.sv */
// How it works
// - event from fail input or expiry tally
// - input picks soft/hard; timer always hard
// - timer counts up; start sets pending flag
// - host writes one to refresh in window
// - timer cleared off, idle until reset released
// - period two to code milliseconds, fused default
// - period rewrite while on restarts timer
// - refresh lowers tally one; miss adds two
// - tally reaching limit starts event
// - limit two or less: first expiry fires
// - window mode accepts second half only
// - enable bit, secure write when secured
// - standby enable bit, secure write when secured
// - both enables default from fuses
// - soft reset keeps host reset released
// - keep bit decides regulator restore
// - sequenced ramp to default, others off
// - settle, 30 us, run, interrupt flag set, mask kept
// - hard: off, delay, 30 us, reload, power
// - after reset, standby request picks standby
// - event tally counts, limit goes fail-safe
// - event tally cleared when off
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "pwem_cfg.svh"
module pwem_device #(
  parameter int unsigned HALF_MS_CYC  = `PWEM_HALF_MS_CYC,
  parameter int unsigned PD_DELAY_CYC = `PWEM_PD_DELAY_CYC
) (
  input  wire logic       clk,               // 10 MHz clock
  input  wire logic       rst,               // async reset, high
  pwem_if.device          bus,               // host side
  input  wire logic       powerGood,         // supply present pin
  input  wire logic       standbyPin,        // standby request pin
  input  wire logic       sharedFailLineN,   // shared fail line pin
  input  wire logic       regSettled,        // outputs settled pin
  input  wire logic       secureModeEn,      // secure-write mode
  input  wire logic [3:0] fusedPeriodCode,   // fused period code
  input  wire logic [2:0] fusedExpiryLimit,  // fused expiry limit
  input  wire logic       fusedWindowMode,   // fused window mode
  input  wire logic       fusedTimerEnable,  // fused timer enable
  input  wire logic       fusedStbyEnable,   // fused standby enable
  input  wire logic [3:0] fusedEventLimit,   // fused event limit
  input  wire logic       fusedResetType,    // fused input reset type
  input  wire logic [3:0] fusedKeep,         // fused keep bits
  input  wire logic [3:0] inSequence,        // regulators in sequence
  output logic      [3:0] regOn,             // regulator enables
  output logic      [3:0] regRestore,        // ramp to default
  output logic      [2:0] pmState            // state code
);
  // ========================================================
  // pin synchronisers
  logic [3:0] s1, s2, s3, filt, next_filt;
  logic       standbyReq, failLineN, pwrOk, settled;
  always_comb begin
    next_filt = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & filt);
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1   <= `PWEM_SYNC_RST;
      s2   <= `PWEM_SYNC_RST;
      s3   <= `PWEM_SYNC_RST;
      filt <= `PWEM_SYNC_RST;
    end else begin
      s1   <= {regSettled, powerGood, standbyPin, sharedFailLineN};
      s2   <= s1;
      s3   <= s2;
      filt <= next_filt;
    end
  end
  assign {settled, pwrOk, standbyReq, failLineN} = filt;
  // ========================================================
  // main state
  function automatic logic [16:0] pwemHalves(input logic [3:0] c);
    pwemHalves = 17'h2 << c;
  endfunction : pwemHalves
  pwem_pkg::pwem_state_type state, next_state;
  logic        timerEn, stbyEn, rstType, irqMask, irqFlag, pending, live, failPrev;
  logic        next_timerEn, next_stbyEn, next_rstType, next_irqMask;
  logic        next_irqFlag, next_pending, next_live, next_failPrev;
  logic        resetN, irqN, next_resetN, next_irqN;
  logic [3:0]  period, keep, evTally, evLimit, next_regOn, next_regRestore;
  logic [3:0]  next_period, next_keep, next_evTally, next_evLimit;
  logic [2:0]  expTally, expLimit, next_expTally, next_expLimit;
  logic [15:0] pre, waitCnt, next_pre, next_waitCnt;
  logic [16:0] halfCnt, next_halfCnt;
  logic [7:0]  rdData, next_rdData;
  logic        onState, timerRun, restart, missed, timerEvt, failEvt;
  logic        loadAll, loadSoft, secOk;
  always_comb begin
    next_state = state;      next_timerEn = timerEn;   next_stbyEn = stbyEn;
    next_rstType = rstType;  next_irqMask = irqMask;   next_irqFlag = irqFlag;
    next_pending = pending;  next_live = live;         next_failPrev = bus.hostFailN;
    next_resetN = resetN;    next_period = period;     next_keep = keep;
    next_evTally = evTally;  next_evLimit = evLimit;   next_expTally = expTally;
    next_expLimit = expLimit; next_pre = pre;          next_waitCnt = waitCnt;
    next_halfCnt = halfCnt;  next_regOn = regOn;       next_regRestore = regRestore;
    restart = 1'b0; missed = 1'b0; timerEvt = 1'b0; loadAll = 1'b0; loadSoft = 1'b0;
    onState = (state == pwem_pkg::PWEM_RUN) || (state == pwem_pkg::PWEM_STBY);
    secOk   = ~secureModeEn | bus.wrSecure;
    failEvt = onState & failPrev & ~bus.hostFailN;
    timerRun = resetN & timerEn & ((state == pwem_pkg::PWEM_RUN) |
               ((state == pwem_pkg::PWEM_STBY) & stbyEn));
    if (bus.wrEn && onState) begin
      unique case (bus.wrAddr)
        `PWEM_R_CTRL: begin
          if (secOk) begin
            next_timerEn = bus.wrData[`PWEM_B_TIMER_EN];
            next_stbyEn  = bus.wrData[`PWEM_B_STBY_EN];
          end
          next_rstType = bus.wrData[`PWEM_B_RST_TYPE];
        end
        `PWEM_R_PERIOD: begin
          next_period = bus.wrData[3:0];
          restart = 1'b1;
        end
        `PWEM_R_REFRESH: begin
          if (bus.wrData[0] && pending && live) begin
            // early refresh in window mode is a miss
            if (fusedWindowMode && (halfCnt < (17'h1 << period))) begin
              missed = 1'b1;
            end else begin
              next_pending = 1'b0;
              restart = 1'b1;
              if (expTally != 3'h0) next_expTally = expTally - `PWEM_EXP_DOWN;
            end
          end
        end
        `PWEM_R_EXPIRY:  next_expLimit = bus.wrData[6:4];
        `PWEM_R_EVTALLY: next_evTally = 4'h0;
        `PWEM_R_EVLIMIT: next_evLimit = bus.wrData[3:0];
        `PWEM_R_IRQ: begin
          if (bus.wrData[0]) next_irqFlag = 1'b0;
          next_irqMask = bus.wrData[`PWEM_B_IRQ_MASK];
        end
        `PWEM_R_KEEP: next_keep = bus.wrData[3:0];
        default: ;
      endcase
    end
    // timer, counted in half milliseconds
    if (!timerRun) begin
      next_live = 1'b0; next_pre = 16'h0; next_halfCnt = 17'h0;
    end else if (!live) begin
      next_live = 1'b1; next_pending = 1'b1;
    end else if (pre == 16'(HALF_MS_CYC - 1)) begin
      next_pre = 16'h0;
      if (halfCnt + 17'h1 == pwemHalves(period)) missed = 1'b1;
      else next_halfCnt = halfCnt + 17'h1;
    end else begin
      next_pre = pre + 16'h1;
    end
    if (missed) begin
      next_expTally = (expTally > 3'h5) ? 3'h7 : expTally + `PWEM_EXP_UP;
      restart = 1'b1;
      timerEvt = (next_expTally >= expLimit) || (expLimit <= `PWEM_EXP_LOW_LIMIT);
    end
    if (restart && timerRun && live) begin
      next_pre = 16'h0; next_halfCnt = 17'h0; next_pending = 1'b1;
    end
    unique case (state)
      pwem_pkg::PWEM_OFF: begin
        loadAll = 1'b1; next_evTally = 4'h0;
        if (pwrOk && failLineN) begin
          next_state = pwem_pkg::PWEM_PWRUP; next_regOn = inSequence;
        end
      end
      pwem_pkg::PWEM_PWRUP: if (settled) begin
        next_resetN = 1'b1;
        next_state = standbyReq ? pwem_pkg::PWEM_STBY : pwem_pkg::PWEM_RUN;
      end
      pwem_pkg::PWEM_RUN:  if (standbyReq) next_state = pwem_pkg::PWEM_STBY;
      pwem_pkg::PWEM_STBY: if (!standbyReq) next_state = pwem_pkg::PWEM_RUN;
      pwem_pkg::PWEM_SOFT: begin
        if (!settled) next_waitCnt = 16'h0;
        else if (waitCnt == 16'(`PWEM_SETTLE_CYC - 1)) begin
          next_regRestore = 4'h0; next_irqFlag = 1'b1;
          next_state = standbyReq ? pwem_pkg::PWEM_STBY : pwem_pkg::PWEM_RUN;
        end else next_waitCnt = waitCnt + 16'h1;
      end
      pwem_pkg::PWEM_HARDDN: begin
        if (waitCnt == 16'(PD_DELAY_CYC - 1)) begin
          next_waitCnt = 16'h0; next_state = pwem_pkg::PWEM_HARDWT;
        end else next_waitCnt = waitCnt + 16'h1;
      end
      pwem_pkg::PWEM_HARDWT: begin
        if (waitCnt == 16'(`PWEM_SETTLE_CYC - 1)) begin
          loadAll = 1'b1;
          if (failLineN) begin
            next_state = pwem_pkg::PWEM_PWRUP; next_regOn = inSequence;
          end
        end else next_waitCnt = waitCnt + 16'h1;
      end
      pwem_pkg::PWEM_FAILSAFE: ;
    endcase
    if (timerEvt || failEvt) begin
      next_evTally = (evTally == 4'hf) ? 4'hf : evTally + 4'h1;
      next_waitCnt = 16'h0;
      if (next_evTally == evLimit) begin
        next_state = pwem_pkg::PWEM_FAILSAFE; next_regOn = 4'h0; next_resetN = 1'b0;
      end else if (failEvt && !timerEvt && rstType) begin
        next_state = pwem_pkg::PWEM_SOFT; loadSoft = 1'b1;
        next_regRestore = ~keep & inSequence;
        next_regOn = regOn & (inSequence | keep);
      end else begin
        next_state = pwem_pkg::PWEM_HARDDN; next_regOn = 4'h0; next_resetN = 1'b0;
      end
    end
    if (!pwrOk) begin
      next_state = pwem_pkg::PWEM_OFF; next_regOn = 4'h0;
      next_regRestore = 4'h0; next_resetN = 1'b0;
    end
    if (loadSoft || loadAll) begin
      next_timerEn = fusedTimerEnable; next_stbyEn = fusedStbyEnable;
      next_period = fusedPeriodCode; next_keep = fusedKeep;
    end
    if (loadAll) begin
      next_expLimit = fusedExpiryLimit; next_evLimit = fusedEventLimit;
      next_rstType = fusedResetType; next_expTally = 3'h0; next_pending = 1'b0;
      next_irqFlag = 1'b0; next_irqMask = 1'b0;
    end
    next_irqN = ~(next_irqFlag & ~next_irqMask);
    unique case (bus.rdAddr)
      `PWEM_R_CTRL:    next_rdData = {5'h0, rstType, stbyEn, timerEn};
      `PWEM_R_PERIOD:  next_rdData = {4'h0, period};
      `PWEM_R_REFRESH: next_rdData = {7'h0, pending};
      `PWEM_R_EXPIRY:  next_rdData = {1'b0, expLimit, 1'b0, expTally};
      `PWEM_R_EVTALLY: next_rdData = {4'h0, evTally};
      `PWEM_R_EVLIMIT: next_rdData = {4'h0, evLimit};
      `PWEM_R_IRQ:     next_rdData = {6'h0, irqMask, irqFlag};
      `PWEM_R_KEEP:    next_rdData = {4'h0, keep};
      `PWEM_R_STATUS:  next_rdData = {5'h0, state};
      default:         next_rdData = `PWEM_RD_RST;
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= pwem_pkg::PWEM_OFF;
      timerEn <= 1'b0;  stbyEn <= 1'b0;  rstType <= 1'b0;  irqMask <= 1'b0;
      irqFlag <= 1'b0;  pending <= 1'b0; live <= 1'b0;     failPrev <= 1'b1;
      resetN <= 1'b0;   irqN <= 1'b1;    period <= 4'h0;   keep <= 4'h0;
      evTally <= 4'h0;  evLimit <= 4'h0; expTally <= 3'h0; expLimit <= 3'h0;
      pre <= 16'h0;     waitCnt <= 16'h0; halfCnt <= 17'h0; rdData <= `PWEM_RD_RST;
      regOn <= 4'h0;    regRestore <= 4'h0;
    end else begin
      state <= next_state;
      timerEn <= next_timerEn;   stbyEn <= next_stbyEn;     rstType <= next_rstType;
      irqMask <= next_irqMask;   irqFlag <= next_irqFlag;   pending <= next_pending;
      live <= next_live;         failPrev <= next_failPrev; resetN <= next_resetN;
      irqN <= next_irqN;         period <= next_period;     keep <= next_keep;
      evTally <= next_evTally;   evLimit <= next_evLimit;   expTally <= next_expTally;
      expLimit <= next_expLimit; pre <= next_pre;           waitCnt <= next_waitCnt;
      halfCnt <= next_halfCnt;   rdData <= next_rdData;
      regOn <= next_regOn;       regRestore <= next_regRestore;
    end
  end
  assign bus.rdData     = rdData;
  assign bus.hostResetN = resetN;
  assign bus.irqN       = irqN;
  assign pmState        = state;
endmodule : pwem_device
`default_nettype wire

/* rtl/pwem_cfg.svh */
`ifndef PWEM_CFG_SVH
`define PWEM_CFG_SVH
// ==========================================================
// timing
`define PWEM_CLK_MHZ        10
`define PWEM_HALF_MS_US     500
`define PWEM_HALF_MS_CYC    (`PWEM_HALF_MS_US * `PWEM_CLK_MHZ)
`define PWEM_SETTLE_US      30
`define PWEM_SETTLE_CYC     (`PWEM_SETTLE_US * `PWEM_CLK_MHZ)
`define PWEM_PD_DELAY_US    100
`define PWEM_PD_DELAY_CYC   (`PWEM_PD_DELAY_US * `PWEM_CLK_MHZ)
// ==========================================================
// expiry tally arithmetic
`define PWEM_EXP_UP         3'h2
`define PWEM_EXP_DOWN       3'h1
`define PWEM_EXP_LOW_LIMIT  3'h2
// ==========================================================
// device register indices (device's own port)
`define PWEM_R_CTRL         4'h0
`define PWEM_R_PERIOD       4'h1
`define PWEM_R_REFRESH      4'h2
`define PWEM_R_EXPIRY       4'h3
`define PWEM_R_EVTALLY      4'h4
`define PWEM_R_EVLIMIT      4'h5
`define PWEM_R_IRQ          4'h6
`define PWEM_R_KEEP         4'h7
`define PWEM_R_STATUS       4'h8
// ==========================================================
// field positions
`define PWEM_B_TIMER_EN     0
`define PWEM_B_STBY_EN      1
`define PWEM_B_RST_TYPE     2
`define PWEM_B_IRQ_MASK     1
// ==========================================================
// reset values
`define PWEM_SYNC_RST       4'h1
`define PWEM_RD_RST         8'h00
// ==========================================================
// host apb offsets
`define PWEM_A_CMD          12'h000
`define PWEM_A_RDADDR       12'h004
`define PWEM_A_RDDATA       12'h008
`define PWEM_A_FAILCTL      12'h00c
`define PWEM_A_STATUS       12'h010
`endif

/* rtl/pwem_pkg.sv */
package pwem_pkg;
  typedef enum logic [2:0] {
    PWEM_OFF      = 3'b000,
    PWEM_PWRUP    = 3'b001,
    PWEM_RUN      = 3'b010,
    PWEM_STBY     = 3'b011,
    PWEM_SOFT     = 3'b100,
    PWEM_HARDDN   = 3'b101,
    PWEM_HARDWT   = 3'b110,
    PWEM_FAILSAFE = 3'b111
  } pwem_state_type;
endpackage : pwem_pkg

/* rtl/pwem_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface pwem_if;
  logic       wrEn;       // one-cycle register write strobe
  logic       wrSecure;   // write is a secure write
  logic [3:0] wrAddr;     // register index of write
  logic [7:0] wrData;     // write data
  logic [3:0] rdAddr;     // register index to read
  logic [7:0] rdData;     // read data, one cycle after rdAddr
  logic       hostFailN;  // host failure input, low = failure
  logic       hostResetN; // host reset, low = held in reset
  logic       irqN;       // interrupt, low = pending
  modport device (input wrEn, wrSecure, wrAddr, wrData, rdAddr, hostFailN,
                  output rdData, hostResetN, irqN);
  modport host (output wrEn, wrSecure, wrAddr, wrData, rdAddr, hostFailN,
                input rdData, hostResetN, irqN);
endinterface : pwem_if
`default_nettype wire

/* rtl/pwem_host.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pwem_cfg.svh"
module pwem_host (
  input  wire logic        clk,     // 10 MHz clock
  input  wire logic        rst,     // async reset, high
  pwem_if.host             bus,     // device side
  input  wire logic [31:0] paddr,   // apb address
  input  wire logic        psel,    // apb select
  input  wire logic        penable, // apb enable
  input  wire logic        pwrite,  // apb direction
  input  wire logic [31:0] pwdata,  // apb write data
  output logic      [31:0] prdata,  // apb read data
  output logic             pready,  // apb ready
  output logic             pslverr  // apb error
);
  // ========================================================
  // apb slave and device drive
  logic        wrEn, wrSecure, failDrive, next_wrEn, next_wrSecure, next_failDrive;
  logic [3:0]  wrAddr, rdAddr, next_wrAddr, next_rdAddr;
  logic [7:0]  wrData, next_wrData;
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr, setup, access, hit;
  always_comb begin
    next_wrEn = 1'b0;         next_wrSecure = wrSecure; next_wrAddr = wrAddr;
    next_wrData = wrData;     next_rdAddr = rdAddr;     next_failDrive = failDrive;
    next_prdata = prdata;     next_pslverr = pslverr;
    setup  = psel & ~penable;
    access = psel & penable & pready;
    // answer is decided in setup so pready comes from a flop
    next_pready = setup;
    hit = 1'b1;
    unique case (paddr[11:0])
      `PWEM_A_CMD:     next_prdata = {19'h0, wrSecure, wrAddr, wrData};
      `PWEM_A_RDADDR:  next_prdata = {28'h0, rdAddr};
      `PWEM_A_RDDATA:  next_prdata = {24'h0, bus.rdData};
      `PWEM_A_FAILCTL: next_prdata = {31'h0, failDrive};
      `PWEM_A_STATUS:  next_prdata = {30'h0, ~bus.hostResetN, ~bus.irqN};
      default: begin
        next_prdata = 32'h0;
        hit = 1'b0;
      end
    endcase
    if (setup) next_pslverr = ~hit | (paddr[1:0] != 2'h0);
    else next_pslverr = 1'b0;
    if (!setup) next_prdata = 32'h0;
    if (access && pwrite && !pslverr) begin
      unique case (paddr[11:0])
        `PWEM_A_CMD: begin
          next_wrEn = 1'b1;
          next_wrData = pwdata[7:0];
          next_wrAddr = pwdata[11:8];
          next_wrSecure = pwdata[12];
        end
        `PWEM_A_RDADDR:  next_rdAddr = pwdata[3:0];
        `PWEM_A_FAILCTL: next_failDrive = pwdata[0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrEn <= 1'b0;   wrSecure <= 1'b0; wrAddr <= 4'h0;   wrData <= 8'h00;
      rdAddr <= 4'h0; failDrive <= 1'b0; prdata <= 32'h0; pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      wrEn <= next_wrEn;     wrSecure <= next_wrSecure;   wrAddr <= next_wrAddr;
      wrData <= next_wrData; rdAddr <= next_rdAddr;       failDrive <= next_failDrive;
      prdata <= next_prdata; pready <= next_pready;       pslverr <= next_pslverr;
    end
  end
  assign bus.wrEn      = wrEn;
  assign bus.wrSecure  = wrSecure;
  assign bus.wrAddr    = wrAddr;
  assign bus.wrData    = wrData;
  assign bus.rdAddr    = rdAddr;
  assign bus.hostFailN = ~failDrive;
endmodule : pwem_host
`default_nettype wire

/* tb/pwem_watch_props.sv */
`timescale 1ns/10ps
`default_nettype none
module pwem_watch_props (
  input wire logic       clk,        // clock
  input wire logic       rst,        // async reset, high
  input wire logic       wrEn,       // register write strobe
  input wire logic       hostResetN, // host reset, low = held
  input wire logic [2:0] pmState,    // device state code
  input wire logic [3:0] regOn       // regulator enables
);
  // ==========================================================
  // cycles spent in a reset sequence
  logic       inRst;
  logic [9:0] rstCnt;
  logic [9:0] next_rstCnt;
  assign inRst = pmState inside {pwem_pkg::PWEM_SOFT, pwem_pkg::PWEM_HARDDN,
                                 pwem_pkg::PWEM_HARDWT};
  // saturates so a stuck sequence cannot wrap into a pass
  always_comb begin
    next_rstCnt = inRst ? rstCnt + {9'h000, ~&rstCnt} : 10'h000;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rstCnt <= 10'h000;
    else rstCnt <= next_rstCnt;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // assertions
  a_soft_keeps_host: assert property (pmState == pwem_pkg::PWEM_SOFT |-> hostResetN)
    else $error("host reset asserted during soft reset");
  a_hard_holds_off: assert property (pmState == pwem_pkg::PWEM_HARDWT |-> !hostResetN && regOn == 4'h0)
    else $error("hard reset wait with host released or regulator on");
  a_failsafe_all_off: assert property ((pmState == pwem_pkg::PWEM_FAILSAFE) [*2] |-> !hostResetN && regOn == 4'h0)
    else $error("fail-safe with host released or regulator on");
  a_off_holds_host: assert property ((pmState == pwem_pkg::PWEM_OFF) [*2] |-> !hostResetN)
    else $error("host released while off");
  a_strobe_one_cycle: assert property (wrEn |=> !wrEn)
    else $error("write strobe longer than one cycle");
  a_reset_min_wait: assert property ($fell(inRst) && pmState != pwem_pkg::PWEM_OFF |-> rstCnt >= 10'd300)
    else $error("reset sequence left before settle wait");
  a_soft_exit_state: assert property (pmState == pwem_pkg::PWEM_SOFT |=> pmState inside {pwem_pkg::PWEM_SOFT, pwem_pkg::PWEM_RUN, pwem_pkg::PWEM_STBY, pwem_pkg::PWEM_OFF})
    else $error("soft reset left to wrong state");
  a_hard_exit_state: assert property (pmState == pwem_pkg::PWEM_HARDWT |=> pmState inside {pwem_pkg::PWEM_HARDWT, pwem_pkg::PWEM_PWRUP, pwem_pkg::PWEM_OFF})
    else $error("hard reset left to wrong state");
  a_event_from_on: assert property ($changed(pmState) && pmState inside {pwem_pkg::PWEM_SOFT, pwem_pkg::PWEM_HARDDN} |-> $past(pmState) inside {pwem_pkg::PWEM_RUN, pwem_pkg::PWEM_STBY})
    else $error("event entered from a non-on state");
  c_soft: cover property (pmState == pwem_pkg::PWEM_SOFT);
  c_hard: cover property (pmState == pwem_pkg::PWEM_HARDWT);
  c_failsafe: cover property (pmState == pwem_pkg::PWEM_FAILSAFE);
endmodule : pwem_watch_props
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pwem_cfg.svh"
module tb;
  logic        clk;
  logic        rst;
  logic        powerGood;
  logic        standbyPin;
  logic        sharedFailLineN;
  logic        regSettled;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  regOn;
  logic [3:0]  regRestore;
  logic [2:0]  pmState;
  logic [7:0]  v;
  logic        vErr;
  logic        secMode;
  logic        fWindow;
  logic        fTimerEn;
  logic        fRstType;
  logic [3:0]  fPeriod;
  logic [3:0]  fKeep;
  logic [2:0]  fExpLim;
  int          n_errors = 0;
  int          n_tests = 0;
  int          cycles = 0;
  // wr, secure, index, write data, expected readback
  logic [21:0] rows [11] = '{
    {2'b00, 4'h0, 8'h00, 8'h06}, {2'b00, 4'h1, 8'h00, 8'h02},
    {2'b00, 4'h3, 8'h00, 8'h60}, {2'b00, 4'h5, 8'h00, 8'h04},
    {2'b10, 4'h0, 8'h01, 8'h02}, {2'b11, 4'h0, 8'h04, 8'h04},
    {2'b10, 4'h7, 8'h0a, 8'h0a}, {2'b10, 4'h1, 8'h03, 8'h03},
    {2'b10, 4'h6, 8'h02, 8'h02}, {2'b10, 4'h6, 8'h00, 8'h00},
    {2'b10, 4'h9, 8'hff, 8'h00}};
  pwem_if i_pwem_if ();
  // fuse straps change only around an off cycle, so reloads pick them up
  pwem_device #(.HALF_MS_CYC(4), .PD_DELAY_CYC(4)) i_pwem_device (
    .clk, .rst, .bus(i_pwem_if), .powerGood, .standbyPin, .sharedFailLineN, .regSettled,
    .secureModeEn(secMode), .fusedPeriodCode(fPeriod), .fusedExpiryLimit(fExpLim),
    .fusedWindowMode(fWindow), .fusedTimerEnable(fTimerEn), .fusedStbyEnable(1'b1),
    .fusedEventLimit(4'h4), .fusedResetType(fRstType), .fusedKeep(fKeep), .inSequence(4'h7),
    .regOn, .regRestore, .pmState);
  pwem_host i_pwem_host (.clk, .rst, .bus(i_pwem_if), .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr);
  pwem_watch_props i_pwem_watch_props (.clk, .rst, .wrEn(i_pwem_if.wrEn),
    .hostResetN(i_pwem_if.hostResetN), .pmState, .regOn);
  // ==========================================================
  // tasks
  task automatic complete_run;
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // waits as long as the slave needs; only the bench timeout ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {20'h00000, a}; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    v = prdata[7:0];
    vErr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic devWrite(input logic s, input logic [3:0] i, input logic [7:0] d);
    apb(1'b1, `PWEM_A_CMD, {19'h00000, s, i, d});
  endtask : devWrite
  // read data lags the index by two cycles through the host
  task automatic devRead(input logic [3:0] i);
    apb(1'b1, `PWEM_A_RDADDR, {28'h0000000, i});
    repeat (2) @(posedge clk);
    apb(1'b0, `PWEM_A_RDDATA, 32'h00000000);
  endtask : devRead
  task automatic waitSt(input logic [2:0] s, input int lim);
    int k;
    k = 0;
    while (pmState !== s && k < lim) begin
      @(posedge clk);
      k++;
    end
    chk("state", {5'h00, s}, {5'h00, pmState});
  endtask : waitSt
  // ==========================================================
  // clock, timeout, sequence
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    rst = 1'b1; powerGood = 1'b1; standbyPin = 1'b0; sharedFailLineN = 1'b1;
    regSettled = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 32'h0; pwdata = 32'h0;
    secMode = 1'b1; fWindow = 1'b0; fTimerEn = 1'b0; fRstType = 1'b1;
    fPeriod = 4'h2; fKeep = 4'h3; fExpLim = 3'h6;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    waitSt(pwem_pkg::PWEM_RUN, 100);
    for (int i = 0; i < 11; i++) begin
      if (rows[i][21]) devWrite(rows[i][20], rows[i][19:16], rows[i][15:8]);
      devRead(rows[i][19:16]);
      chk("register", rows[i][7:0], v);
    end
    $display("test table done");
    apb(1'b0, 12'h014, 32'h00000000);
    chk("slave error", 8'h01, {7'h00, vErr});
    devWrite(1'b1, 4'h0, 8'h05);
    devRead(4'h2);
    chk("pending", 8'h01, v);
    repeat (70) @(posedge clk);
    devRead(4'h3);
    chk("expiry miss", 8'h62, v);
    devWrite(1'b0, 4'h2, 8'h01);
    devRead(4'h3);
    chk("expiry refresh", 8'h61, v);
    waitSt(pwem_pkg::PWEM_HARDDN, 400);
    sharedFailLineN <= 1'b0;
    repeat (400) @(posedge clk);
    chk("held by fail line", {5'h00, pwem_pkg::PWEM_HARDWT}, {5'h00, pmState});
    sharedFailLineN <= 1'b1;
    waitSt(pwem_pkg::PWEM_RUN, 100);
    devRead(4'h4);
    chk("event tally", 8'h01, v);
    devRead(4'h0);
    chk("reload", 8'h06, v);
    $display("test timer hard done");
    apb(1'b1, `PWEM_A_FAILCTL, 32'h1);
    waitSt(pwem_pkg::PWEM_SOFT, 20);
    chk("restore", 8'h04, {4'h0, regRestore});
    chk("kept on", 8'h03, {4'h0, regOn & 4'hb});
    apb(1'b1, `PWEM_A_FAILCTL, 32'h0);
    waitSt(pwem_pkg::PWEM_RUN, 400);
    chk("irq", 8'h00, {7'h00, i_pwem_if.irqN});
    devWrite(1'b0, 4'h6, 8'h01);
    repeat (3) @(posedge clk);
    chk("irq clear", 8'h01, {7'h00, i_pwem_if.irqN});
    $display("test soft done");
    apb(1'b1, `PWEM_A_FAILCTL, 32'h1);
    waitSt(pwem_pkg::PWEM_SOFT, 20);
    standbyPin <= 1'b1;
    apb(1'b1, `PWEM_A_FAILCTL, 32'h0);
    waitSt(pwem_pkg::PWEM_STBY, 400);
    apb(1'b1, `PWEM_A_FAILCTL, 32'h1);
    waitSt(pwem_pkg::PWEM_FAILSAFE, 20);
    apb(1'b1, `PWEM_A_FAILCTL, 32'h0);
    $display("test standby failsafe done");
    powerGood <= 1'b0;
    standbyPin <= 1'b0;
    secMode <= 1'b0; fWindow <= 1'b1; fTimerEn <= 1'b1;
    fPeriod <= 4'h4; fKeep <= 4'h5; fExpLim <= 3'h2;
    waitSt(pwem_pkg::PWEM_OFF, 20);
    powerGood <= 1'b1;
    waitSt(pwem_pkg::PWEM_RUN, 100);
    devRead(4'h4);
    chk("tally off", 8'h00, v);
    $display("test off done");
    devWrite(1'b0, 4'h0, 8'h05);
    devRead(4'h0);
    chk("open write", 8'h05, v);
    devRead(4'h7);
    chk("keep reload", 8'h05, v);
    // refresh lands well inside the first half of the period
    devWrite(1'b0, 4'h2, 8'h01);
    waitSt(pwem_pkg::PWEM_HARDDN, 20);
    $display("test window done");
    complete_run();
  end
endmodule : tb
`default_nettype wire
